// [rtl/gpb_port.sv]
`timescale 1ns/10ps
`include "gpb_defs.svh"

module gpb_port (
	// Clock and reset
	input  wire logic               sys_clk,
	input  wire logic               resetn,
	// Peripheral bus
	input  wire gpb_pkg::gpb_addr_t bus_addr,
	input  wire logic               bus_sel,
	input  wire logic               bus_wr,
	input  wire gpb_pkg::gpb_data_t bus_wdata,
	output gpb_pkg::gpb_data_t      bus_rdata,
	output logic                    bus_ack,
	// Pins
	input  wire gpb_pkg::gpb_pins_t pin_in,
	output gpb_pkg::gpb_pins_t      pin_out,
	output gpb_pkg::gpb_pins_t      pin_oe
);
	import gpb_pkg::*;

	gpb_pins_t  pin_sync;
	gpb_pins_t  level_view;
	gpb_state_e state_q;
	gpb_state_e state_d;
	logic [1:0] fill_q;
	logic [1:0] fill_d;
	gpb_pins_t  dir_q;
	gpb_pins_t  dir_d;
	gpb_pins_t  latch_q;
	gpb_pins_t  latch_d;
	gpb_data_t  rdata_q;
	gpb_data_t  rdata_d;
	logic       ack_q;
	logic       ack_d;
	logic       run_now;
	logic       fill_done;
	logic       capture_now;
	logic       hit_dir;
	logic       hit_level;
	logic       wr_dir;
	logic       wr_level;
	logic       rd_req;

	// ----------------------------------------
	// Input synchroniser
	// ----------------------------------------
	gpb_sync u_sync (
		.sys_clk  (sys_clk),
		.resetn   (resetn),
		.pin_in   (pin_in),
		.pin_sync (pin_sync)
	);

	// ----------------------------------------
	// Start-up sequence
	// ----------------------------------------
	always_comb begin
		state_d = state_q;
		fill_d  = fill_q;
		case (state_q)
			GPB_ST_RESET: begin
				// Hold off until the synchroniser carries real pin levels
				if (fill_done) begin
					state_d = GPB_ST_RUN;
				end else begin
					fill_d = fill_q + 2'h1;
				end
			end
			GPB_ST_RUN: begin
				state_d = GPB_ST_RUN;
			end
			default: begin
				state_d = GPB_ST_RUN;
			end
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			state_q <= GPB_ST_RESET;
			fill_q  <= 2'h0;
		end else begin
			state_q <= state_d;
			fill_q  <= fill_d;
		end
	end

	// ----------------------------------------
	// Access decode
	// ----------------------------------------
	always_comb begin
		run_now     = (state_q == GPB_ST_RUN);
		fill_done   = (fill_q == `GPB_SYNC_FILL);
		capture_now = (state_q == GPB_ST_RESET) && fill_done;
		hit_dir     = bus_sel && (bus_addr == `GPB_ADDR_DIRECTION);
		hit_level   = bus_sel && (bus_addr == `GPB_ADDR_LEVEL);
		// Writes are ignored until the sequence reaches GPB_ST_RUN so the start-up capture cannot be lost
		wr_dir      = run_now && hit_dir && bus_wr;
		wr_level    = run_now && hit_level && bus_wr;
		rd_req      = bus_sel && !bus_wr;
	end

	// ----------------------------------------
	// Direction register
	// ----------------------------------------
	always_comb begin
		dir_d = dir_q;
		if (wr_dir) begin
			// Upper byte is reserved and dropped
			dir_d = bus_wdata[`GPB_PINS-1:0];
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			dir_q <= `GPB_DIRECTION_RESET;
		end else begin
			dir_q <= dir_d;
		end
	end

	// ----------------------------------------
	// Output latch
	// ----------------------------------------
	always_comb begin
		latch_d = latch_q;
		if (capture_now) begin
			// Take the settled pin levels once after reset
			latch_d = pin_sync;
		end else if (wr_level) begin
			latch_d = bus_wdata[`GPB_PINS-1:0];
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			latch_q <= '0;
		end else begin
			latch_q <= latch_d;
		end
	end

	// ----------------------------------------
	// Per-pin read view
	// ----------------------------------------
	always_comb begin
		for (int i = 0; i < `GPB_PINS; i++) begin
			if (dir_q[i]) begin
				// Output pins read back their latch
				level_view[i] = latch_q[i];
			end else begin
				// Input pins read the synchronised level
				level_view[i] = pin_sync[i];
			end
		end
	end

	// ----------------------------------------
	// Read data
	// ----------------------------------------
	always_comb begin
		rdata_d = rdata_q;
		if (rd_req) begin
			if (hit_dir) begin
				rdata_d = {`GPB_RESERVED_READ, dir_q};
			end else if (hit_level) begin
				rdata_d = {`GPB_RESERVED_READ, level_view};
			end else begin
				// Unmapped reads return zero
				rdata_d = '0;
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			rdata_q <= '0;
		end else begin
			rdata_q <= rdata_d;
		end
	end

	// ----------------------------------------
	// Acknowledge
	// ----------------------------------------
	always_comb begin
		// Every selected cycle is answered, mapped or not
		ack_d = bus_sel;
	end

	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= ack_d;
		end
	end

	// ----------------------------------------
	// Pin outputs
	// ----------------------------------------
	assign pin_out   = latch_q;
	assign pin_oe    = dir_q;

	// ----------------------------------------
	// Bus outputs
	// ----------------------------------------
	assign bus_rdata = rdata_q;
	assign bus_ack   = ack_q;

endmodule // gpb_port

// [rtl/gpb_defs.svh]
`ifndef GPB_DEFS_SVH
`define GPB_DEFS_SVH

// ----------------------------------------
// Register map
// ----------------------------------------
`define GPB_ADDR_W          16
`define GPB_DATA_W          16
`define GPB_PINS            8
`define GPB_ADDR_DIRECTION  16'h3400
`define GPB_ADDR_LEVEL      16'h3401
`define GPB_DIRECTION_RESET 8'h00
`define GPB_RESERVED_READ   8'h00

// ----------------------------------------
// Timing
// ----------------------------------------
`define GPB_SYNC_FILL       2'h2

`endif

// [rtl/gpb_pkg.sv]
`include "gpb_defs.svh"

package gpb_pkg;

	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef logic [`GPB_ADDR_W-1:0] gpb_addr_t;
	typedef logic [`GPB_DATA_W-1:0] gpb_data_t;
	typedef logic [`GPB_PINS-1:0]   gpb_pins_t;

	typedef enum logic [1:0] {
		GPB_ST_RESET = 2'b01,
		GPB_ST_RUN   = 2'b10
	} gpb_state_e;

endpackage

// [rtl/gpb_sync.sv]
`timescale 1ns/10ps
`include "gpb_defs.svh"

module gpb_sync (
	// Clock and reset
	input  wire logic            sys_clk,
	input  wire logic            resetn,
	// Levels
	input  wire gpb_pkg::gpb_pins_t pin_in,
	output gpb_pkg::gpb_pins_t      pin_sync
);
	import gpb_pkg::*;

	gpb_pins_t stage1_q;
	gpb_pins_t stage1_d;
	gpb_pins_t stage2_q;
	gpb_pins_t stage2_d;

	// ----------------------------------------
	// Two-flop synchroniser
	// ----------------------------------------
	always_comb begin
		stage1_d = pin_in;
		stage2_d = stage1_q;
	end

	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			stage1_q <= '0;
			stage2_q <= '0;
		end else begin
			stage1_q <= stage1_d;
			stage2_q <= stage2_d;
		end
	end

	assign pin_sync = stage2_q;

endmodule // gpb_sync

// [test/gpb_checker.sv]
`timescale 1ns/10ps
module gpb_checker (
	// Clock and bus
	input wire logic        sys_clk,
	input wire logic        resetn,
	input wire logic [15:0] bus_addr,
	input wire logic        bus_sel,
	input wire logic        bus_wr,
	input wire logic [15:0] bus_wdata,
	input wire logic [15:0] bus_rdata,
	input wire logic        bus_ack,
	// Pins
	input wire logic [7:0]  pin_out,
	input wire logic [7:0]  pin_oe
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!resetn);
	wire logic dir_wr = bus_sel && bus_wr && bus_addr == 16'h3400;
	wire logic lvl_wr = bus_sel && bus_wr && bus_addr == 16'h3401;
	wire logic dir_rd = bus_sel && !bus_wr && bus_addr == 16'h3400;
	wire logic lvl_rd = bus_sel && !bus_wr && bus_addr == 16'h3401;
	AST_ACK: assert property (bus_sel |=> bus_ack) else $error("no ack");
	AST_NOACK: assert property (!bus_sel |=> !bus_ack) else $error("stray ack");
	AST_DIRW: assert property (dir_wr |=> {8'h00, pin_oe} == ($past(bus_wdata) & 16'h00FF))
		else $error("bad dir");
	AST_LVLW: assert property (lvl_wr |=> {8'h00, pin_out} == ($past(bus_wdata) & 16'h00FF))
		else $error("bad latch");
	AST_RSV: assert property (bus_ack |-> bus_rdata[15:8] == 8'h00) else $error("hi");
	AST_DIRR: assert property (dir_rd |=> bus_rdata == {8'h00, pin_oe})
		else $error("bad dir read");
	AST_OUTR: assert property (lvl_rd |=> (bus_rdata[7:0] & pin_oe) == (pin_out & pin_oe))
		else $error("bad latch read");
	AST_HOLD: assert property (!dir_wr |=> $stable(pin_oe)) else $error("dir moved");
endmodule // gpb_checker

bind gpb_port gpb_checker chk (.sys_clk(sys_clk), .resetn(resetn), .bus_addr(bus_addr),
	.bus_sel(bus_sel), .bus_wr(bus_wr), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
	.bus_ack(bus_ack), .pin_out(pin_out), .pin_oe(pin_oe));

// [test/gpb_board.sv]
`timescale 1ns/10ps
module gpb_board (
	// Pins
	input  wire gpb_pkg::gpb_pins_t pin_out,
	input  wire gpb_pkg::gpb_pins_t pin_oe,
	input  wire gpb_pkg::gpb_pins_t ext_level,
	output gpb_pkg::gpb_pins_t      pin_in
);
	import gpb_pkg::*;
	assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule // gpb_board

// [test/gpb_port_test.sv]
`timescale 1ns/10ps
module gpb_port_test;
	import gpb_pkg::*;
	logic      sys_clk = 0, resetn = 0, bus_sel = 0, bus_wr = 0, bus_ack;
	gpb_addr_t bus_addr = '0;
	gpb_data_t bus_wdata = '0, bus_rdata;
	gpb_pins_t pin_in, pin_out, pin_oe, ext_level = 8'hC3;
	int        num_errors = 0, total_checks = 0;
	always #5 sys_clk = ~sys_clk;
	gpb_port dut (.sys_clk(sys_clk), .resetn(resetn), .bus_addr(bus_addr), .bus_sel(bus_sel),
		.bus_wr(bus_wr), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .bus_ack(bus_ack),
		.pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe));
	gpb_board board (.pin_out(pin_out), .pin_oe(pin_oe), .ext_level(ext_level), .pin_in(pin_in));
	task test_done;
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	// Read expects d back; write sends d
	task acc(input gpb_addr_t a, input logic w, input gpb_data_t d);
		@(posedge sys_clk);
		#1;
		bus_sel = 1;
		bus_wr = w;
		bus_addr = a;
		bus_wdata = d;
		@(posedge sys_clk);
		#1;
		bus_sel = 0;
		total_checks++;
		if (bus_ack !== 1'b1 || (!w && bus_rdata !== d)) begin
			num_errors++;
			$display("unexpected rdata at %h: exp %h got %h", a, d, bus_rdata);
		end
	endtask
	task chk(input string n, input gpb_pins_t e, input gpb_pins_t g);
		total_checks++;
		if (g !== e) begin
			num_errors++;
			$display("unexpected %s: exp %h got %h", n, e, g);
		end
	endtask
	task t_reset;
		acc(16'h3400, 0, 16'h0000);
		acc(16'h3401, 0, 16'h00C3);
		chk("pin_oe", 8'h00, pin_oe);
		chk("pin_out", 8'hC3, pin_out);
		$display("t_reset done");
	endtask
	task t_dir;
		acc(16'h3400, 1, 16'hFF0F);
		acc(16'h3400, 0, 16'h000F);
		chk("pin_oe", 8'h0F, pin_oe);
		chk("pin_out", 8'hC3, pin_out);
		$display("t_dir done");
	endtask
	task t_out;
		acc(16'h3401, 1, 16'hAB5A);
		chk("pin_out", 8'h5A, pin_out);
		acc(16'h3401, 0, 16'h00CA);
		$display("t_out done");
	endtask
	task t_in;
		ext_level = 8'h5E;
		acc(16'h3401, 0, 16'h00CA);
		repeat (4) @(posedge sys_clk);
		acc(16'h3401, 0, 16'h005A);
		$display("t_in done");
	endtask
	task t_map;
		acc(16'h3402, 1, 16'hFFFF);
		acc(16'h3402, 0, 16'h0000);
		acc(16'h3400, 0, 16'h000F);
		chk("pin_out", 8'h5A, pin_out);
		$display("t_map done");
	endtask
	initial begin
		repeat (2) @(posedge sys_clk);
		#1;
		resetn = 1;
		repeat (3) @(posedge sys_clk);
		t_reset;
		t_dir;
		t_out;
		t_in;
		t_map;
		test_done;
	end
	initial begin
		#2000;
		num_errors++;
		test_done;
	end
endmodule // gpb_port_test
